// ===== hdl/arrc_top.sv
// Rate-of-change alarm, output ramp and clamp logic with Avalon-MM registers
// Functional notes
// - Rate is sample difference over elapsed time
// - Falling change uses negative threshold, rising positive
// - Alarm when rate exceeds applicable threshold
// - Diagnostic and fault enables steer alarm reports
// - Compare each interval; reject interval below 60ms
// - Hold off detection 100ms after run/power
// - New ramp from present output on word change
// - Zero ramp rate moves output directly
// - Time mode reaches target in 1ms-32s
// - Step mode moves 1-32000 counts per ms
// - Command mode persists; reconfiguration leaves it alone
// - Cancel returns to configured ramp rate
// - Ramping off snaps output to command
// - Step command during time ramp acts at once
// - Time command restarts ramp from present output
// - Invalid command discarded, error code reported
// - Error stays until clear command or reconfigure
// - Above upper limit: clamp, condition, optional alarm
// - Below lower limit: clamp, condition, optional alarm
// - Clamping off: limits follow scale values
// - Upper above lower, neither more than a margin beyond its scale end
// - Scale change keeps limits; re-enable restores defaults
//
// The address map and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module arrc_top #(
  parameter int MS_CYCLES = arrc_pkg::MS_CYCLES_DEF,
  parameter logic signed [15:0] CLAMP_MARGIN = arrc_pkg::CLAMP_MARGIN_DEF
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [arrc_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Input channel
  input wire logic signed [15:0] sample_i,
  input wire logic sample_valid_i,
  input wire logic run_mode_i,
  input wire logic field_power_i,
  // Output channel
  input wire logic signed [15:0] commanded_output_word_i,
  output logic signed [15:0] analog_out_o,
  // Conditions and reports
  output logic clamp_upper_o,
  output logic clamp_lower_o,
  output logic roc_alarm_o,
  output logic diag_report_o,
  output logic fault_report_o,
  output logic [2:0] err_code_o
);
  import arrc_pkg::*;
  localparam int MS_W = $clog2(MS_CYCLES);

  function automatic logic signed [15:0] sat16(input logic signed [17:0] v);
    if (v > EU_MAX) return EU_MAX[15:0];
    if (v < EU_MIN) return EU_MIN[15:0];
    return v[15:0];
  endfunction

  function automatic logic signed [17:0] ext18(input logic signed [15:0] v);
    return {{2{v[15]}}, v};
  endfunction

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  // Bus handshake: one wait cycle, then answer
  logic wr_acc;
  logic [31:0] rd_mux;
  assign wr_acc = avs_write_i && !avs_waitrequest_o;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0;
    end else if (avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= rd_mux;
    end
  end

  // Configuration registers
  logic [CTRL_W-1:0] ctrl;
  logic [15:0] cfg_ramp_rate;
  logic signed [15:0] high_scale;
  logic signed [15:0] low_scale;
  logic signed [15:0] upper_lim;
  logic signed [15:0] lower_lim;
  logic [15:0] roc_neg_thr;
  logic [15:0] roc_pos_thr;
  logic [15:0] roc_interval;
  logic [15:0] wdata16;
  logic cfg_wr;
  logic clamp_en;
  logic clamp_en_q;
  logic signed [17:0] heu;
  logic signed [17:0] leu;
  logic up_ok;
  logic lo_ok;
  logic int_ok;
  assign wdata16 = avs_writedata_i[15:0];
  assign clamp_en = ctrl[CTRL_CLAMP_EN];
  assign cfg_wr = wr_acc && avs_address_i <= OFS_ROC_INT && avs_address_i[1:0] == 2'h0;
  assign heu = ext18(high_scale) + ext18(CLAMP_MARGIN);
  assign leu = ext18(low_scale) - ext18(CLAMP_MARGIN);
  assign up_ok = clamp_en && $signed(wdata16) > lower_lim && ext18(wdata16) <= heu;
  assign lo_ok = clamp_en && $signed(wdata16) < upper_lim && ext18(wdata16) >= leu;
  assign int_ok = wdata16 >= 16'(ROC_MIN_MS);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= '0;
      cfg_ramp_rate <= 16'h0;
      high_scale <= RST_HIGH_SCALE;
      low_scale <= RST_LOW_SCALE;
      roc_neg_thr <= 16'h0;
      roc_pos_thr <= 16'h0;
      roc_interval <= 16'(ROC_MIN_MS);
    end else if (wr_acc) begin
      case (avs_address_i)
        OFS_CTRL: ctrl <= avs_writedata_i[CTRL_W-1:0];
        OFS_RAMP_RATE: cfg_ramp_rate <= wdata16;
        OFS_HIGH_SCALE: high_scale <= wdata16;
        OFS_LOW_SCALE: low_scale <= wdata16;
        OFS_ROC_NEG: roc_neg_thr <= wdata16;
        OFS_ROC_POS: roc_pos_thr <= wdata16;
        OFS_ROC_INT: if (int_ok) roc_interval <= wdata16;
        default: ;
      endcase
    end
  end

  // Clamp limits
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      clamp_en_q <= 1'b0;
      upper_lim <= RST_HIGH_SCALE;
      lower_lim <= RST_LOW_SCALE;
    end else begin
      clamp_en_q <= clamp_en;
      if (!clamp_en) begin
        upper_lim <= high_scale;
        lower_lim <= low_scale;
      end else if (!clamp_en_q) begin
        upper_lim <= sat16(heu);
        lower_lim <= sat16(leu);
      end else if (wr_acc && avs_address_i == OFS_UPPER_LIM && up_ok) begin
        upper_lim <= wdata16;
      end else if (wr_acc && avs_address_i == OFS_LOWER_LIM && lo_ok) begin
        lower_lim <= wdata16;
      end
    end
  end

  // Host command decode
  logic cmd_wr;
  logic [3:0] cmd_op;
  logic [3:0] cmd_ch;
  logic [15:0] cmd_data;
  logic cmd_ok;
  logic [2:0] err_new;
  logic err_clr;
  assign cmd_wr = wr_acc && avs_address_i == OFS_CMD;
  assign cmd_op = avs_writedata_i[3:0];
  assign cmd_ch = avs_writedata_i[CMD_CH_LSB+3:CMD_CH_LSB];
  assign cmd_data = avs_writedata_i[CMD_DATA_LSB+15:CMD_DATA_LSB];

  always_comb begin
    err_new = ERR_NONE;
    if (cmd_wr) begin
      if (cmd_op > OP_CLEAR) begin
        err_new = ERR_OP;
      end else if (cmd_op != OP_CLEAR && cmd_ch >= OUT_CHANNELS) begin
        err_new = ERR_CHAN;
      end else if (cmd_op == OP_STEP
                   && (cmd_data < 16'(STEP_MIN) || cmd_data > 16'(STEP_MAX))) begin
        err_new = ERR_STEP;
      end else if (cmd_op == OP_TIME
                   && (cmd_data < 16'(RAMP_MIN_MS) || cmd_data > 16'(RAMP_MAX_MS))) begin
        err_new = ERR_TIME;
      end
    end else if (wr_acc) begin
      if ((avs_address_i == OFS_UPPER_LIM && !up_ok)
          || (avs_address_i == OFS_LOWER_LIM && !lo_ok)
          || (avs_address_i == OFS_ROC_INT && !int_ok)) begin
        err_new = ERR_CFG;
      end
    end
  end

  assign cmd_ok = cmd_wr && err_new == ERR_NONE;
  assign err_clr = (cmd_ok && cmd_op == OP_CLEAR) || cfg_wr;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      err_code_o <= ERR_NONE;
    end else if (err_new != ERR_NONE) begin
      err_code_o <= err_new;
    end else if (err_clr) begin
      err_code_o <= ERR_NONE;
    end
  end

  // Ramp mode, kept apart from configuration writes
  arrc_mode_type mode;
  logic [15:0] cmd_time;
  logic [15:0] cmd_step;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mode <= MODE_CFG;
      cmd_time <= 16'h0;
      cmd_step <= 16'h0;
    end else if (cmd_ok) begin
      case (cmd_op)
        OP_CANCEL: mode <= MODE_CFG;
        OP_TIME: begin
          mode <= MODE_TIME;
          cmd_time <= cmd_data;
        end
        OP_STEP: begin
          mode <= MODE_STEP;
          cmd_step <= cmd_data;
        end
        default: ;
      endcase
    end
  end

  // Millisecond tick
  logic [MS_W-1:0] ms_cnt;
  logic ms_tick;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ms_cnt <= '0;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= ms_cnt == MS_W'(MS_CYCLES - 1);
      ms_cnt <= (ms_cnt == MS_W'(MS_CYCLES - 1)) ? '0 : ms_cnt + 1'b1;
    end
  end

  // Step size for time mode: ceiling of distance over ramp time
  logic signed [15:0] target;
  logic signed [15:0] ramp_val;
  logic signed [15:0] cmd_word_q;
  logic signed [15:0] next_tgt;
  logic signed [17:0] tgt_dist;
  logic word_chg;
  logic div_go;
  logic div_busy;
  logic [4:0] div_cnt;
  logic [16:0] div_num;
  logic [16:0] div_rem;
  logic [16:0] div_den;
  logic [16:0] rem_sh;
  logic [16:0] time_step;
  assign word_chg = commanded_output_word_i != cmd_word_q;
  assign next_tgt = word_chg ? commanded_output_word_i : target;
  assign tgt_dist = ext18(next_tgt) - ext18(ramp_val);
  assign div_go = (word_chg && mode == MODE_TIME) || (cmd_ok && cmd_op == OP_TIME);
  assign rem_sh = {div_rem[15:0], div_num[16]};

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      div_busy <= 1'b0;
      div_cnt <= 5'h0;
      div_num <= 17'h0;
      div_rem <= 17'h0;
      div_den <= 17'h1;
      time_step <= 17'h0;
    end else if (div_go) begin
      div_busy <= 1'b1;
      div_cnt <= 5'(DIV_STEPS);
      div_num <= tgt_dist[17] ? 17'(-tgt_dist) : tgt_dist[16:0];
      div_rem <= 17'h0;
      div_den <= {1'b0, (cmd_ok && cmd_op == OP_TIME) ? cmd_data : cmd_time};
    end else if (div_busy && div_cnt != 5'h0) begin
      div_cnt <= div_cnt - 5'h1;
      if (rem_sh >= div_den) begin
        div_rem <= rem_sh - div_den;
        div_num <= {div_num[15:0], 1'b1};
      end else begin
        div_rem <= rem_sh;
        div_num <= {div_num[15:0], 1'b0};
      end
    end else if (div_busy) begin
      div_busy <= 1'b0;
      time_step <= div_num + {16'h0, div_rem != 17'h0};
    end
  end

  // Ramp generator
  logic [16:0] eff_step;
  logic signed [17:0] r_diff;
  logic signed [17:0] r_step;
  logic signed [15:0] next_ramp;
  logic ramp_hold;
  // Only a time-mode ramp waits for the divider
  assign ramp_hold = div_busy && mode == MODE_TIME;
  always_comb begin
    case (mode)
      MODE_CFG: eff_step = {1'b0, cfg_ramp_rate};
      MODE_TIME: eff_step = time_step;
      MODE_STEP: eff_step = {1'b0, cmd_step};
      default: eff_step = 17'h0;
    endcase
    r_diff = ext18(target) - ext18(ramp_val);
    r_step = {1'b0, eff_step};
    if (r_diff > r_step) begin
      next_ramp = 16'(ext18(ramp_val) + r_step);
    end else if (r_diff < -r_step) begin
      next_ramp = 16'(ext18(ramp_val) - r_step);
    end else begin
      next_ramp = target;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_word_q <= 16'sh0;
      target <= 16'sh0;
      ramp_val <= 16'sh0;
    end else begin
      cmd_word_q <= commanded_output_word_i;
      if (word_chg) target <= commanded_output_word_i;
      if (eff_step == 17'h0 && !ramp_hold) begin
        ramp_val <= target;
      end else if (ms_tick && !ramp_hold) begin
        ramp_val <= next_ramp;
      end
    end
  end

  // Clamping of the ramp output and clamp conditions
  logic hi_cond;
  logic lo_cond;
  logic hi_alm;
  logic lo_alm;
  logic rpt_path;
  assign hi_cond = clamp_en && target > upper_lim;
  assign lo_cond = clamp_en && target < lower_lim;
  assign rpt_path = ctrl[CTRL_DIAG_EN] || ctrl[CTRL_FAULT_EN];
  assign hi_alm = hi_cond && !clamp_upper_o && ctrl[CTRL_UPPER_ALM] && rpt_path;
  assign lo_alm = lo_cond && !clamp_lower_o && ctrl[CTRL_LOWER_ALM] && rpt_path;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      analog_out_o <= 16'sh0;
      clamp_upper_o <= 1'b0;
      clamp_lower_o <= 1'b0;
    end else begin
      clamp_upper_o <= hi_cond;
      clamp_lower_o <= lo_cond;
      if (ramp_val > upper_lim) begin
        analog_out_o <= upper_lim;
      end else if (ramp_val < lower_lim) begin
        analog_out_o <= lower_lim;
      end else begin
        analog_out_o <= ramp_val;
      end
    end
  end

  // Rate-of-change detection
  logic run_q;
  logic pwr_q;
  logic restart;
  logic [6:0] holdoff;
  logic [15:0] roc_cnt;
  logic roc_eval;
  logic signed [15:0] latest;
  logic signed [15:0] prev;
  logic prev_valid;
  logic signed [16:0] s_diff;
  logic [16:0] s_mag;
  logic [31:0] lhs;
  logic [31:0] rhs_neg;
  logic [31:0] rhs_pos;
  logic roc_en;
  logic neg_hit;
  logic pos_hit;
  assign restart = (run_mode_i && !run_q) || (field_power_i && !pwr_q);
  assign roc_eval = ms_tick && holdoff == 7'h0 && roc_cnt == roc_interval - 16'h1;
  assign s_diff = {latest[15], latest} - {prev[15], prev};
  assign s_mag = s_diff[16] ? 17'(-s_diff) : 17'(s_diff);
  assign lhs = 32'(s_mag) * 32'(MS_PER_S);
  assign rhs_neg = 32'(roc_neg_thr) * 32'(roc_interval);
  assign rhs_pos = 32'(roc_pos_thr) * 32'(roc_interval);
  assign roc_en = roc_neg_thr != 16'h0 || roc_pos_thr != 16'h0;
  assign neg_hit = roc_eval && prev_valid && roc_en && s_diff[16] && lhs > rhs_neg;
  assign pos_hit = roc_eval && prev_valid && roc_en && !s_diff[16] && lhs > rhs_pos;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      run_q <= 1'b0;
      pwr_q <= 1'b0;
      holdoff <= 7'(HOLDOFF_MS);
      roc_cnt <= 16'h0;
    end else begin
      run_q <= run_mode_i;
      pwr_q <= field_power_i;
      if (restart) begin
        holdoff <= 7'(HOLDOFF_MS);
        roc_cnt <= 16'h0;
      end else if (ms_tick) begin
        if (holdoff != 7'h0) holdoff <= holdoff - 7'h1;
        roc_cnt <= (roc_eval || holdoff != 7'h0) ? 16'h0 : roc_cnt + 16'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      latest <= 16'sh0;
      prev <= 16'sh0;
      prev_valid <= 1'b0;
    end else begin
      if (sample_valid_i) latest <= sample_i;
      if (restart) begin
        prev_valid <= 1'b0;
      end else if (roc_eval) begin
        prev <= latest;
        prev_valid <= 1'b1;
      end
    end
  end

  // Alarm reports and sticky status, set wins over clear
  logic [3:0] sticky;
  logic [3:0] st_set;
  logic [3:0] st_clr;
  assign st_set = {lo_alm, hi_alm, pos_hit, neg_hit};
  assign st_clr = (wr_acc && avs_address_i == OFS_STATUS) ? avs_writedata_i[3:0] : 4'h0;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sticky <= 4'h0;
      roc_alarm_o <= 1'b0;
      diag_report_o <= 1'b0;
      fault_report_o <= 1'b0;
    end else begin
      sticky <= (sticky & ~st_clr) | st_set;
      roc_alarm_o <= neg_hit || pos_hit;
      diag_report_o <= ctrl[CTRL_DIAG_EN] && st_set != 4'h0;
      fault_report_o <= ctrl[CTRL_FAULT_EN] && st_set != 4'h0;
    end
  end

  always_comb begin
    case (avs_address_i)
      OFS_CTRL: rd_mux = {27'h0, ctrl};
      OFS_RAMP_RATE: rd_mux = {16'h0, cfg_ramp_rate};
      OFS_HIGH_SCALE: rd_mux = {16'h0, high_scale};
      OFS_LOW_SCALE: rd_mux = {16'h0, low_scale};
      OFS_UPPER_LIM: rd_mux = {16'h0, upper_lim};
      OFS_LOWER_LIM: rd_mux = {16'h0, lower_lim};
      OFS_ROC_NEG: rd_mux = {16'h0, roc_neg_thr};
      OFS_ROC_POS: rd_mux = {16'h0, roc_pos_thr};
      OFS_ROC_INT: rd_mux = {16'h0, roc_interval};
      OFS_STATUS: rd_mux = {18'h0, mode, 1'b0, err_code_o, 4'h0, sticky};
      OFS_OUTPUT: rd_mux = {16'h0, analog_out_o};
      default: rd_mux = 32'h0;
    endcase
  end

  // Checks
  sequence s_bad_chan;
    cmd_wr && cmd_op == OP_STEP && cmd_ch >= OUT_CHANNELS;
  endsequence
  property p_bad_chan;
    s_bad_chan |=> err_code_o == ERR_CHAN && mode == $past(mode);
  endproperty
  a_bad_chan: assert property (p_bad_chan) else $error("bad channel not reported");
  property p_err_hold;
    err_code_o != ERR_NONE && !err_clr && err_new == ERR_NONE |=> $stable(err_code_o);
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error code lost");
  property p_direct;
    eff_step == 17'h0 && !div_busy |=> ramp_val == $past(target);
  endproperty
  a_direct: assert property (p_direct) else $error("direct move missed");
  property p_no_over;
    ms_tick && !div_busy && ramp_val < target |=> ramp_val <= $past(target);
  endproperty
  a_no_over: assert property (p_no_over) else $error("ramp overshoot");
  property p_clamp_out;
    ##1 1'b1 |-> analog_out_o <= $past(upper_lim) && analog_out_o >= $past(lower_lim)
      || $past(upper_lim) < $past(lower_lim);
  endproperty
  a_clamp_out: assert property (p_clamp_out) else $error("output beyond limit");
  property p_holdoff;
    holdoff != 7'h0 |-> !roc_eval ##1 !roc_alarm_o;
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("detection during hold-off");
  property p_interval;
    roc_interval >= 16'(ROC_MIN_MS);
  endproperty
  a_interval: assert property (p_interval) else $error("interval below minimum");
  property p_mode_keep;
    cfg_wr |=> mode == $past(mode);
  endproperty
  a_mode_keep: assert property (p_mode_keep) else $error("mode changed by config");
  property p_limit_dflt;
    clamp_en && !clamp_en_q |=> upper_lim == sat16($past(heu)) && lower_lim == sat16($past(leu));
  endproperty
  a_limit_dflt: assert property (p_limit_dflt) else $error("limit defaults wrong");
  property p_report;
    (neg_hit || pos_hit) && ctrl[CTRL_DIAG_EN]
      |=> diag_report_o && roc_alarm_o && sticky[1:0] != 2'h0;
  endproperty
  a_report: assert property (p_report) else $error("rate alarm not reported");
endmodule // arrc_top
`default_nettype wire

// ===== hdl/arrc_pkg.sv
// Constants and types for the rate-of-change, ramp and clamp block
`default_nettype none
package arrc_pkg;
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_RAMP_RATE = 6'h04;
  localparam logic [5:0] OFS_HIGH_SCALE = 6'h08;
  localparam logic [5:0] OFS_LOW_SCALE = 6'h0c;
  localparam logic [5:0] OFS_UPPER_LIM = 6'h10;
  localparam logic [5:0] OFS_LOWER_LIM = 6'h14;
  localparam logic [5:0] OFS_ROC_NEG = 6'h18;
  localparam logic [5:0] OFS_ROC_POS = 6'h1c;
  localparam logic [5:0] OFS_ROC_INT = 6'h20;
  localparam logic [5:0] OFS_CMD = 6'h24;
  localparam logic [5:0] OFS_STATUS = 6'h28;
  localparam logic [5:0] OFS_OUTPUT = 6'h2c;
  localparam int CTRL_W = 5;
  localparam int CTRL_CLAMP_EN = 0;
  localparam int CTRL_DIAG_EN = 1;
  localparam int CTRL_FAULT_EN = 2;
  localparam int CTRL_UPPER_ALM = 3;
  localparam int CTRL_LOWER_ALM = 4;
  localparam int ST_ERR_LSB = 8;
  localparam int ST_MODE_LSB = 12;
  localparam int CMD_CH_LSB = 4;
  localparam int CMD_DATA_LSB = 16;
  localparam logic [3:0] OP_CANCEL = 4'h0;
  localparam logic [3:0] OP_TIME = 4'h1;
  localparam logic [3:0] OP_STEP = 4'h2;
  localparam logic [3:0] OP_CLEAR = 4'h3;
  localparam logic [3:0] OUT_CHANNELS = 4'h1;
  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_CHAN = 3'h1;
  localparam logic [2:0] ERR_STEP = 3'h2;
  localparam logic [2:0] ERR_TIME = 3'h3;
  localparam logic [2:0] ERR_OP = 3'h4;
  localparam logic [2:0] ERR_CFG = 3'h5;
  typedef enum logic [1:0] {MODE_CFG, MODE_TIME, MODE_STEP} arrc_mode_type;
  localparam int CLK_HZ = 250_000_000;
  localparam int MS_PER_S = 1000;
  localparam int TICK_MS = 1;
  localparam int MS_CYCLES_DEF = CLK_HZ / MS_PER_S * TICK_MS;
  localparam int ROC_MIN_MS = 60;
  localparam int HOLDOFF_MS = 100;
  localparam int RAMP_MIN_MS = 1;
  localparam int RAMP_MAX_S = 32;
  localparam int RAMP_MAX_MS = RAMP_MAX_S * MS_PER_S;
  localparam int STEP_MIN = 1;
  localparam int STEP_MAX = 32000;
  localparam int DIV_STEPS = 17;
  localparam logic signed [15:0] RST_HIGH_SCALE = 16'sh7d00;
  localparam logic signed [15:0] RST_LOW_SCALE = 16'sh0000;
  localparam logic signed [15:0] CLAMP_MARGIN_DEF = 16'sh0100;
  localparam logic signed [17:0] EU_MAX = 18'sh07fff;
  localparam logic signed [17:0] EU_MIN = -18'sh08000;
endpackage
`default_nettype wire

// ===== testbench/arrc_host_model.sv
// Host controller model issuing register bus transfers
`timescale 1ns/100ps
`default_nettype none
module arrc_host_model (
  // Clock
  input wire logic clk_sys_i,
  // Register bus
  output logic [arrc_pkg::ADDR_W-1:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [31:0] avs_writedata_o,
  input wire logic [31:0] avs_readdata_i,
  input wire logic avs_waitrequest_i
);
  import arrc_pkg::*;
  initial begin
    avs_address_o = 6'h00;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = 32'h0;
  end
  // Holds the request until waitrequest is seen low
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_sys_i);
    avs_address_o <= a;
    avs_write_o <= wr;
    avs_read_o <= !wr;
    avs_writedata_o <= d;
    do @(posedge clk_sys_i); while (avs_waitrequest_i !== 1'b0);
    q = avs_readdata_i;
    avs_write_o <= 1'b0;
    avs_read_o <= 1'b0;
  endtask
endmodule // arrc_host_model
`default_nettype wire

// ===== testbench/test_analog_roc_ramp_clamp.sv
// Self-checking bench for the rate, ramp and clamp block
`timescale 1ns/100ps
`default_nettype none
module test_analog_roc_ramp_clamp;
  import arrc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, sv = 1'b1, run = 1'b0, pwr = 1'b1, rd_w, wr_w, wq;
  logic [5:0] adr;
  logic [31:0] wd, rdat, q;
  logic signed [15:0] smp = 16'sh0000, cw = 16'sh0000, ao;
  logic cu, cl, ra, dg, ft;
  logic [2:0] err;
  int fails = 0, cmp_count = 0;
  arrc_top #(.MS_CYCLES(10)) u_dut (.clk_sys_i(clk), .rst_i(rst), .avs_address_i(adr),
    .avs_read_i(rd_w), .avs_write_i(wr_w), .avs_writedata_i(wd), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wq), .sample_i(smp), .sample_valid_i(sv), .run_mode_i(run),
    .field_power_i(pwr), .commanded_output_word_i(cw), .analog_out_o(ao),
    .clamp_upper_o(cu), .clamp_lower_o(cl), .roc_alarm_o(ra), .diag_report_o(dg),
    .fault_report_o(ft), .err_code_o(err));
  arrc_host_model u_host (.clk_sys_i(clk), .avs_address_o(adr), .avs_read_o(rd_w),
    .avs_write_o(wr_w), .avs_writedata_o(wd), .avs_readdata_i(rdat),
    .avs_waitrequest_i(wq));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t %s: %h vs %h", $time, m, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q);
    // Let the write's effect settle before anything is judged
    @(posedge clk);
  endtask
  task automatic rd(input logic [5:0] a);
    u_host.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic word(input logic signed [15:0] v);
    @(posedge clk);
    cw <= v;
  endtask
  task automatic wait_out(input logic signed [15:0] e, input int n);
    for (int i = 0; i < n && ao !== e; i++) @(posedge clk);
    chk({16'h0, ao}, {16'h0, e}, "output");
  endtask
  task automatic t_regs;
    rd(OFS_HIGH_SCALE);
    chk(q, 32'h7d00, "high scale");
    rd(OFS_UPPER_LIM);
    chk(q, 32'h7d00, "upper limit");
    rd(6'h3c);
    chk(q, 32'h0, "unmapped");
  endtask
  task automatic t_step;
    word(16'sh1000);
    wait_out(16'sh1000, 8);
    wr(OFS_CMD, {16'h0100, 12'h0, OP_STEP});
    word(16'sh1300);
    repeat (5) @(posedge clk);
    chk({31'h0, ao === 16'sh1300}, 32'h0, "early");
    wait_out(16'sh1300, 60);
    repeat (30) @(posedge clk);
    chk({16'h0, ao}, 32'h1300, "overshoot");
    wr(OFS_CMD, {16'h0000, 12'h0, OP_STEP});
    chk({29'h0, err}, {29'h0, ERR_STEP}, "bad step");
    rd(OFS_STATUS);
    chk(32'(q[13:12]), 32'h2, "mode kept");
    wr(OFS_RAMP_RATE, 32'h0);
    chk({29'h0, err}, {29'h0, ERR_NONE}, "cleared");
    rd(OFS_STATUS);
    chk(32'(q[13:12]), 32'h2, "mode after cfg");
  endtask
  task automatic t_time;
    wr(OFS_CMD, {16'h0005, 12'h0, OP_TIME});
    word(16'sh1800);
    repeat (20) @(posedge clk);
    chk({31'h0, ao === 16'sh1800}, 32'h0, "time early");
    wait_out(16'sh1800, 100);
    wr(OFS_CMD, {16'h0001, 12'h0, OP_STEP});
    word(16'sh2000);
    wr(OFS_CMD, {16'h0000, 12'h0, OP_CANCEL});
    wait_out(16'sh2000, 12);
    wr(OFS_CMD, {16'h0001, 12'h1, OP_STEP});
    chk({29'h0, err}, {29'h0, ERR_CHAN}, "bad channel");
    wr(OFS_CMD, {16'h0000, 12'h0, OP_CLEAR});
    chk({29'h0, err}, {29'h0, ERR_NONE}, "clear cmd");
  endtask
  task automatic t_clamp;
    wr(OFS_CTRL, 32'h1);
    wr(OFS_UPPER_LIM, 32'h3000);
    word(16'sh4000);
    wait_out(16'sh3000, 8);
    repeat (2) @(posedge clk);
    chk({31'h0, cu}, 32'h1, "upper flag");
    word(16'shf000);
    wait_out(16'shff00, 8);
    repeat (2) @(posedge clk);
    chk({31'h0, cl}, 32'h1, "lower flag");
    wr(OFS_UPPER_LIM, 32'hfe00);
    chk({29'h0, err}, {29'h0, ERR_CFG}, "limit order");
    rd(OFS_UPPER_LIM);
    chk(q, 32'h3000, "limit kept");
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 32'h1);
    rd(OFS_UPPER_LIM);
    chk(q, 32'h7e00, "limit default");
  endtask
  task automatic t_roc;
    int hits;
    hits = 0;
    wr(OFS_ROC_INT, 32'd59);
    chk({29'h0, err}, {29'h0, ERR_CFG}, "short interval");
    wr(OFS_CTRL, 32'h7);
    wr(OFS_ROC_POS, 32'd1000);
    @(posedge clk);
    run <= 1'b1;
    for (int i = 0; i < 2200; i++) @(posedge clk) hits += int'(ra === 1'b1);
    chk(32'(hits), 32'h0, "quiet");
    smp <= 16'sh01f4;
    for (int i = 0; i < 1400 && ra !== 1'b1; i++) @(posedge clk);
    chk({31'h0, ra}, 32'h1, "rate alarm");
    chk({30'h0, dg, ft}, 32'h3, "reports");
    rd(OFS_STATUS);
    chk(32'(q[1:0]), 32'h2, "rate dir");
    smp <= 16'sh0000;
    for (int i = 0; i < 1400 && ra !== 1'b1; i++) @(posedge clk);
    chk({31'h0, ra}, 32'h1, "fall alarm");
    rd(OFS_STATUS);
    chk(32'(q[1:0]), 32'h3, "fall dir");
  endtask
  task automatic end_of_test;
    if (fails == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_step();
    t_time();
    t_clamp();
    t_roc();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test();
  end
endmodule // test_analog_roc_ramp_clamp
`default_nettype wire
